/* hdl/wdt_map.vh */
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ----------------------------------------
// interval select codes
// ----------------------------------------
`define WDT_SEL_2P15 2'h0
`define WDT_SEL_2P18 2'h1
`define WDT_SEL_2P21 2'h2
`define WDT_SEL_2P24 2'h3

// ----------------------------------------
// timing counts in system clocks
// ----------------------------------------
`define WDT_TIMEOUT_2P15 32'h00008000
`define WDT_TIMEOUT_2P18 32'h00040000
`define WDT_TIMEOUT_2P21 32'h00200000
`define WDT_TIMEOUT_2P24 32'h01000000
`define WDT_RESET_CYCLES 32'h00000200

// ----------------------------------------
// counter values
// ----------------------------------------
`define WDT_COUNT_RESET 32'h00000000
`define WDT_COUNT_STEP 32'h00000001

`endif

/* hdl/wdt_top.v */
`timescale 1ns/1ps
// Overview of operation
// - free-running counter; restart reloads starting value
// - interval select picks 2^15/18/21/24 clocks
// - timeout raises interrupt only when enabled
// - reset interval is exactly 512 clocks
// - unrestarted reset interval expiry asserts system reset
`include "wdt_map.vh"

module wdt_top #(
  parameter [31:0] TIMEOUT_2P15 = `WDT_TIMEOUT_2P15,
  parameter [31:0] TIMEOUT_2P18 = `WDT_TIMEOUT_2P18,
  parameter [31:0] TIMEOUT_2P21 = `WDT_TIMEOUT_2P21,
  parameter [31:0] TIMEOUT_2P24 = `WDT_TIMEOUT_2P24,
  parameter [31:0] RESET_CYCLES = `WDT_RESET_CYCLES
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_enable,
  input wire i_restart,
  input wire [1:0] i_interval_select,
  input wire i_irq_enable,
  output reg o_irq,
  output reg o_timeout,
  output reg o_system_reset
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_COUNT = 3'h2;
  localparam [2:0] ST_RESET_WIN = 3'h4;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] sel_timeout;
    input [1:0] sel;
    begin
      case (sel)
        `WDT_SEL_2P15: sel_timeout = TIMEOUT_2P15;
        `WDT_SEL_2P18: sel_timeout = TIMEOUT_2P18;
        `WDT_SEL_2P21: sel_timeout = TIMEOUT_2P21;
        default: sel_timeout = TIMEOUT_2P24;
      endcase
    end
  endfunction

  // last cycle of a span of len clocks; a len of zero is not supported
  function at_terminal;
    input [31:0] count;
    input [31:0] len;
    begin
      at_terminal = (count >= len - 32'h00000001);
    end
  endfunction

  // both counting states clear the counter on the same three causes
  function must_clear;
    input run;
    input kick;
    input done;
    begin
      must_clear = !run || kick || done;
    end
  endfunction

  // ----------------------------------------
  // storage and nets
  // ----------------------------------------
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [31:0] count_reg;
  reg [31:0] count_next;
  reg irq_next;
  reg timeout_next;
  reg sysrst_next;
  wire [31:0] limit;
  wire in_count;
  wire in_window;
  wire period_done;
  wire window_done;
  wire fire_timeout;
  wire fire_reset;

  // ----------------------------------------
  // interval decode
  // ----------------------------------------
  // select change takes effect at the next compare; no restart implied
  assign limit = sel_timeout(i_interval_select);

  // ----------------------------------------
  // state flags
  // ----------------------------------------
  assign in_count = (state_reg == ST_COUNT);
  assign in_window = (state_reg == ST_RESET_WIN);

  // ----------------------------------------
  // terminal detection
  // ----------------------------------------
  assign period_done = at_terminal(count_reg, limit);
  // independent of interval select: fixed window
  assign window_done = at_terminal(count_reg, RESET_CYCLES);
  // restart wins over expiry in the same cycle
  assign fire_timeout = in_count && i_enable && !i_restart && period_done;
  assign fire_reset = in_window && i_enable && !i_restart && window_done;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (i_enable) begin
          state_next = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!i_enable) begin
          state_next = ST_IDLE;
        end else if (fire_timeout) begin
          state_next = ST_RESET_WIN;
        end
      end
      ST_RESET_WIN: begin
        if (!i_enable) begin
          state_next = ST_IDLE;
        end else if (i_restart) begin
          state_next = ST_COUNT;
        end else if (fire_reset) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        // a corrupted code falls back to idle rather than locking up
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // next count
  // ----------------------------------------
  always @* begin
    count_next = count_reg + `WDT_COUNT_STEP;
    case (state_reg)
      ST_IDLE: begin
        count_next = `WDT_COUNT_RESET;
      end
      ST_COUNT: begin
        if (must_clear(i_enable, i_restart, fire_timeout)) begin
          count_next = `WDT_COUNT_RESET;
        end
      end
      ST_RESET_WIN: begin
        if (must_clear(i_enable, i_restart, fire_reset)) begin
          count_next = `WDT_COUNT_RESET;
        end
      end
      default: begin
        count_next = `WDT_COUNT_RESET;
      end
    endcase
  end

  // ----------------------------------------
  // output decode
  // ----------------------------------------
  always @* begin
    timeout_next = 1'b0;
    irq_next = 1'b0;
    sysrst_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // a restart seen here has nothing to cancel
        timeout_next = 1'b0;
        irq_next = 1'b0;
        sysrst_next = 1'b0;
      end
      ST_COUNT: begin
        timeout_next = fire_timeout;
        irq_next = fire_timeout && i_irq_enable;
      end
      ST_RESET_WIN: begin
        sysrst_next = fire_reset;
      end
      default: begin
        timeout_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      count_reg <= `WDT_COUNT_RESET;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  // pulses, not sticky flags: the consumer must latch them
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_timeout <= 1'b0;
      o_system_reset <= 1'b0;
    end else begin
      o_irq <= irq_next;
      o_timeout <= timeout_next;
      o_system_reset <= sysrst_next;
    end
  end

endmodule

/* sim/wdt_monitor.sv */
`timescale 1ns/1ps
module wdt_monitor #(
  parameter [31:0] RESET_CYCLES = 32'h00000200
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_enable,
  input wire i_restart,
  input wire [1:0] i_interval_select,
  input wire i_irq_enable,
  input wire o_irq,
  input wire o_timeout,
  input wire o_system_reset
);
  reg [31:0] win_cnt;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // a counter instead of a 512-deep $past history
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) win_cnt <= 32'h00000000;
    else if (o_timeout) win_cnt <= 32'h00000001;
    else if (win_cnt != 32'h00000000) win_cnt <= win_cnt + 32'h00000001;
  end
  a_irq_gate: assert property (o_irq == (o_timeout && $past(i_irq_enable)))
    else $error("irq gating wrong");
  a_reset_gap: assert property (o_system_reset |-> win_cnt == RESET_CYCLES)
    else $error("reset off window");
  a_kick_wins: assert property (i_restart |=> !o_timeout && !o_system_reset)
    else $error("restart lost");
  a_rst_clear: assert property ($past(i_rst) |-> !o_irq && !o_timeout && !o_system_reset)
    else $error("outputs not clear after reset");
  a_timeout_single: assert property (o_timeout |=> !o_timeout)
    else $error("timeout pulse too long");
  a_reset_single: assert property (o_system_reset |=> !o_system_reset && !o_timeout)
    else $error("reset pulse too long");
  cover property (o_irq);
  cover property (o_timeout && !o_irq);
  cover property (o_system_reset);
endmodule
bind wdt_top wdt_monitor #(.RESET_CYCLES(RESET_CYCLES)) u_mon (
  .i_clock(i_clock),
  .i_rst(i_rst),
  .i_enable(i_enable),
  .i_restart(i_restart),
  .i_interval_select(i_interval_select),
  .i_irq_enable(i_irq_enable),
  .o_irq(o_irq),
  .o_timeout(o_timeout),
  .o_system_reset(o_system_reset)
);

/* sim/watchdog_timeout_reset_bench.sv */
`timescale 1ns/1ps
module watchdog_timeout_reset_bench;
  reg i_clock = 0, i_rst = 1, i_enable = 1, i_restart = 0, i_irq_enable = 0;
  reg [1:0] i_interval_select = 0;
  wire o_irq, o_timeout, o_system_reset;
  integer n_mismatch = 0, tests_run = 0, cyc = 0, n, s;
  always #20 i_clock = ~i_clock;
  localparam [31:0] T0 = 32'h00000010;
  localparam [31:0] T1 = 32'h00000020;
  localparam [31:0] T2 = 32'h00000040;
  localparam [31:0] T3 = 32'h00000080;
  localparam [31:0] RST = 32'h00000008;
  // shortened spans keep the run short
  wdt_top #(
    .TIMEOUT_2P15(T0),
    .TIMEOUT_2P18(T1),
    .TIMEOUT_2P21(T2),
    .TIMEOUT_2P24(T3),
    .RESET_CYCLES(RST)
  ) dut (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_enable(i_enable),
    .i_restart(i_restart),
    .i_interval_select(i_interval_select),
    .i_irq_enable(i_irq_enable),
    .o_irq(o_irq),
    .o_timeout(o_timeout),
    .o_system_reset(o_system_reset)
  );
  // ceiling about two and a half times the ~420 cycles the tests need
  always @(posedge i_clock) if (++cyc == 1000) summarize;
  task summarize;
    if (cyc >= 1000) n_mismatch++;
    $display("%0d fails in %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) $display("[FAIL] %s exp %0d got %0d", nm, e, g);
    if (g !== e) n_mismatch++;
  endtask
  function [31:0] exp_period(input [1:0] sel);
    case (sel)
      2'h0: exp_period = T0;
      2'h1: exp_period = T1;
      2'h2: exp_period = T2;
      default: exp_period = T3;
    endcase
  endfunction
  // bounded wait, cycles since the call land in n
  task hold(input w);
    n = 0;
    do @(posedge i_clock) #1 n++;
    while ((w ? o_system_reset : o_timeout) !== 1'h1 && n < 300);
  endtask
  task t_period(input [1:0] sel);
    @(posedge i_clock) i_restart <= 1'h1;
    i_interval_select <= sel;
    i_irq_enable <= sel[0];
    @(posedge i_clock) i_restart <= 1'h0;
    hold(0);
    chk("period", exp_period(sel), n);
    chk("irq", sel[0], o_irq);
    hold(1);
    chk("gap", RST, n);
    $display("period test %0d done", sel);
  endtask
  // restart inside the reset window cancels it and rearms a full period
  task t_window_kick;
    @(posedge i_clock) i_restart <= 1'h1;
    i_interval_select <= 2'h0;
    @(posedge i_clock) i_restart <= 1'h0;
    hold(0);
    chk("kick timeout", T0, n);
    repeat (3) @(posedge i_clock);
    i_restart <= 1'h1;
    @(posedge i_clock) i_restart <= 1'h0;
    hold(1);
    chk("kick rearm", T0 + RST, n);
    $display("window restart test done");
  endtask
  // dropping enable for one cycle parks the counter at its start
  task t_disable;
    @(posedge i_clock) i_restart <= 1'h1;
    @(posedge i_clock) i_restart <= 1'h0;
    repeat (4) @(posedge i_clock);
    i_enable <= 1'h0;
    @(posedge i_clock) i_enable <= 1'h1;
    hold(0);
    chk("enable rearm", T0 + 32'h00000001, n);
    hold(1);
    chk("enable gap", RST, n);
    $display("enable test done");
  endtask
  // a reset inside the window must leave nothing pending
  task t_mid_reset;
    @(posedge i_clock) i_restart <= 1'h1;
    @(posedge i_clock) i_restart <= 1'h0;
    hold(0);
    chk("pre-reset timeout", T0, n);
    @(posedge i_clock) i_rst <= 1'h1;
    @(posedge i_clock) i_rst <= 1'h0;
    hold(1);
    chk("reset rearm", T0 + RST + 32'h00000001, n);
    $display("mid-run reset test done");
  endtask
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 1'h0;
    @(posedge i_clock) #1 chk("rst", 0, o_timeout);
    for (s = 0; s < 4; s++) t_period(s);
    t_window_kick;
    t_disable;
    t_mid_reset;
    summarize;
  end
endmodule
